/* File: core/speech_cmd_pkg.sv */
// Purpose: shared types of the status, fault and phrase command slice
// Assumes: constants from status_fault_regs.svh
// Notes:   whole block state is one packed struct
`include "status_fault_regs.svh"
package speech_cmd_pkg;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_SEL    = 3'b001,
        PH_HI     = 3'b010,
        PH_LO     = 3'b011,
        PH_RESP   = 3'b100,
        PH_DROP   = 3'b101
    } phase_e;

    typedef struct packed {
        logic [1:0] src;
        logic [3:0] mask;
    } route_s;

    typedef struct packed {
        logic [2:0]       sck_q;
        logic [2:0]       csn_q;
        logic [2:0]       si_q;
        logic             sck_f;
        logic             csn_f;
        logic             si_f;
        phase_e           phase;
        logic [2:0]       bit_cnt;
        logic [6:0]       rx;
        logic [7:0]       tx;
        logic             so;
        logic [1:0]       ph_ch;
        logic [3:0]       ph_hi;
        logic [3:0][11:0] phrase;
        logic [3:0]       pend;
        logic [3:0]       start;
        route_s           route_a;
        route_s           route_b;
        logic             stat_a;
        logic             stat_b;
        logic [7:0]       fault;
        logic             wdt_seen;
        logic [7:0]       safe_en;
        logic [7:0]       rom_info;
        logic [31:0]      prdata;
    } state_s;

endpackage

/* File: core/status_fault_readout_phrase_select.sv */
// Purpose: host command decode for state, rom info and fault reads,
//          status pin routing and wide phrase select
// Assumes: serial host link sampled on pclk; flags and detectors
//          come from logic on pclk
// Notes:   apb gives software access to the same state
`timescale 1ns/1ps
`include "status_fault_regs.svh"

// What this block does
// - read-state opcode returns active flags high nibble, accept flags low.
// - accept and active flags reflect channel processing and playback.
// - rom-info opcode returns the eight-bit sound rom information value.
// - fault-read opcode returns the eight fault bits in fixed order.
// - erroneous host command sets the command fault bit.
// - speaker open detector sets the speaker open fault bit.
// - overtemperature detector sets the overtemperature fault bit.
// - speaker short detector sets the speaker short fault bit.
// - flash error sets the flash fault bit.
// - first watchdog overflow sets the watchdog fault bit.
// - second watchdog overflow or reset counter overflow sets reset bit.
// - oscillator stop sets the oscillator stop fault bit.
// - status-select port bit chooses the first or second status pin.
// - source field picks active flag, accept flag or fault output.
// - each status pin keeps its own routing independently.
// - after reset pin a shows ch0 accept, pin b ch0 active.
// - channel mask applies to flag sources; several channels allowed.
// - wide phrase select carries channel and twelve-bit phrase.
// - wide phrase select accepted only while that channel accepts.
// - chosen phrase waits for a later start, then plays.
// - fault clear clears fault bits; persisting faults stay set.
// - each detector stays off until its enable bit is set.
module status_fault_readout_phrase_select #(
    parameter logic [7:0] ROM_INFO_INIT = `ROM_INFO_RESET
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             host_sck,
    input  wire logic             host_csn,
    input  wire logic             host_si,
    output logic                  host_so,
    input  wire logic [3:0]       active_flag_n,
    input  wire logic [3:0]       cmd_accept_flag,
    input  wire logic             det_osc_stop,
    input  wire logic             det_rst_ovf,
    input  wire logic             det_wdt_ovf,
    input  wire logic             det_flash,
    input  wire logic             det_spk_short,
    input  wire logic             det_overtemp,
    input  wire logic             det_spk_open,
    output logic                  status_out_a,
    output logic                  status_out_b,
    output logic [3:0][11:0]      phrase_num_bits,
    output logic [3:0]            play_start
);

    localparam speech_cmd_pkg::state_s RST = '{
        sck_q:    3'h0,
        csn_q:    3'h7,
        si_q:     3'h0,
        sck_f:    1'b0,
        csn_f:    1'b1,
        si_f:     1'b0,
        phase:    speech_cmd_pkg::PH_OPCODE,
        bit_cnt:  3'h0,
        rx:       7'h00,
        tx:       8'h00,
        so:       1'b0,
        ph_ch:    2'h0,
        ph_hi:    4'h0,
        phrase:   48'h0,
        pend:     4'h0,
        start:    4'h0,
        route_a:  `ROUTE_A_INIT,
        route_b:  `ROUTE_B_INIT,
        stat_a:   1'b1,
        stat_b:   1'b1,
        fault:    8'h00,
        wdt_seen: 1'b0,
        safe_en:  8'h00,
        rom_info: ROM_INFO_INIT,
        prdata:   32'h0000_0000
    };

    speech_cmd_pkg::state_s s_r;
    speech_cmd_pkg::state_s s_nxt;

    logic       rise;
    logic       fall;
    logic [7:0] byte_v;
    logic [7:0] set_v;
    logic [7:0] en_v;
    logic       clr;
    logic       cmd_err;
    logic       mapped;
    logic [31:0] rd_v;

    function automatic logic route_out(
        input speech_cmd_pkg::route_s r,
        input logic [3:0]             act_n,
        input logic [3:0]             acc,
        input logic                   flt
    );
        logic v;
        v = flt;
        if (r.src == `SRC_ACTIVE) begin
            v = &(act_n | ~r.mask);
        end else if (r.src == `SRC_ACCEPT) begin
            v = &(acc | ~r.mask);
        end
        return v;
    endfunction

    always_comb begin
        s_nxt   = s_r;
        byte_v  = 8'h00;
        set_v   = 8'h00;
        en_v    = 8'h00;
        clr     = 1'b0;
        cmd_err = 1'b0;
        mapped  = 1'b1;
        rd_v    = 32'h0000_0000;

        // three-stage pin sampling, change taken when the last two stages agree
        s_nxt.sck_q = {s_r.sck_q[1:0], host_sck};
        s_nxt.csn_q = {s_r.csn_q[1:0], host_csn};
        s_nxt.si_q  = {s_r.si_q[1:0], host_si};
        if (s_r.sck_q[2] == s_r.sck_q[1]) begin
            s_nxt.sck_f = s_r.sck_q[2];
        end
        if (s_r.csn_q[2] == s_r.csn_q[1]) begin
            s_nxt.csn_f = s_r.csn_q[2];
        end
        if (s_r.si_q[2] == s_r.si_q[1]) begin
            s_nxt.si_f = s_r.si_q[2];
        end
        rise = s_nxt.sck_f & ~s_r.sck_f;
        fall = ~s_nxt.sck_f & s_r.sck_f;

        // start plays pending phrases once, then clears them
        s_nxt.start = 4'h0;
        if (psel && penable && pwrite && paddr == `OFF_CTRL) begin
            if (pwdata[`CTRL_START_BIT]) begin
                s_nxt.start = s_r.pend;
                s_nxt.pend  = 4'h0;
            end
            clr = pwdata[`CTRL_CLEAR_BIT];
        end

        // serial framing
        if (s_r.csn_f) begin
            s_nxt.phase   = speech_cmd_pkg::PH_OPCODE;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.so      = 1'b0;
        end else if (rise) begin
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            s_nxt.rx      = {s_r.rx[5:0], s_nxt.si_f};
            if (s_r.bit_cnt == 3'h7) begin
                byte_v = {s_r.rx, s_nxt.si_f};
                unique case (s_r.phase)
                    speech_cmd_pkg::PH_OPCODE: begin
                        s_nxt.phase = speech_cmd_pkg::PH_RESP;
                        if (byte_v == `OP_READ_STATE) begin
                            s_nxt.tx = {active_flag_n,
                                        cmd_accept_flag};
                        end else if (byte_v == `OP_ROM_INFO) begin
                            s_nxt.tx = s_r.rom_info;
                        end else if (byte_v[7:1] == `OP_READ_FAULT) begin
                            s_nxt.tx = s_r.fault;
                        end else if (byte_v == `OP_STATUS_SEL) begin
                            s_nxt.phase = speech_cmd_pkg::PH_SEL;
                        end else if (byte_v == `OP_WIDE_PHRASE) begin
                            s_nxt.phase = speech_cmd_pkg::PH_HI;
                        end else if (byte_v == `OP_FAULT_CLEAR) begin
                            clr         = 1'b1;
                            s_nxt.phase = speech_cmd_pkg::PH_DROP;
                        end else begin
                            cmd_err     = 1'b1;
                            s_nxt.phase = speech_cmd_pkg::PH_DROP;
                        end
                        if (s_nxt.phase == speech_cmd_pkg::PH_RESP) begin
                            s_nxt.so = s_nxt.tx[7];
                            s_nxt.tx = {s_nxt.tx[6:0], 1'b0};
                        end
                    end
                    speech_cmd_pkg::PH_SEL: begin
                        s_nxt.phase = speech_cmd_pkg::PH_DROP;
                        if (byte_v[`SEL_ZERO_BIT]) begin
                            cmd_err = 1'b1;
                        end else if (byte_v[`SEL_PORT_BIT]) begin
                            s_nxt.route_b = byte_v[5:0];
                        end else begin
                            s_nxt.route_a = byte_v[5:0];
                        end
                    end
                    speech_cmd_pkg::PH_HI: begin
                        s_nxt.phase = speech_cmd_pkg::PH_DROP;
                        s_nxt.ph_ch = byte_v[`PH_CH_HI:`PH_CH_LO];
                        s_nxt.ph_hi = byte_v[3:0];
                        if (byte_v[`PH_ZERO_HI] || byte_v[`PH_ZERO_LO]) begin
                            cmd_err = 1'b1;
                        end else if (!cmd_accept_flag[s_nxt.ph_ch]) begin
                            cmd_err = 1'b1;
                        end else begin
                            s_nxt.phase = speech_cmd_pkg::PH_LO;
                        end
                    end
                    speech_cmd_pkg::PH_LO: begin
                        s_nxt.phase = speech_cmd_pkg::PH_DROP;
                        s_nxt.phrase[s_r.ph_ch] = {s_r.ph_hi,
                                                   byte_v};
                        s_nxt.pend[s_r.ph_ch]   = 1'b1;
                    end
                    speech_cmd_pkg::PH_RESP,
                    speech_cmd_pkg::PH_DROP: begin
                        // bytes after a response are dropped
                        s_nxt.phase = speech_cmd_pkg::PH_DROP;
                    end
                    default: begin
                        s_nxt.phase = speech_cmd_pkg::PH_DROP;
                    end
                endcase
            end
        end else if (fall && s_r.phase == speech_cmd_pkg::PH_RESP
                     && s_r.bit_cnt != 3'h0) begin
            s_nxt.so = s_r.tx[7];
            s_nxt.tx = {s_r.tx[6:0], 1'b0};
        end

        // fault detection, each gated by its enable
        en_v = s_r.safe_en;
        set_v[`F_OSC]   = en_v[`F_OSC] & det_osc_stop;
        set_v[`F_FLASH] = en_v[`F_FLASH] & det_flash;
        set_v[`F_SHORT] = en_v[`F_SHORT] & det_spk_short;
        set_v[`F_TEMP]  = en_v[`F_TEMP] & det_overtemp;
        set_v[`F_OPEN]  = en_v[`F_OPEN] & det_spk_open;
        set_v[`F_CMD]   = en_v[`F_CMD] & cmd_err;
        set_v[`F_WDT]   = en_v[`F_WDT] & det_wdt_ovf
                          & ~s_r.wdt_seen;
        set_v[`F_RST]   = (en_v[`F_WDT] & det_wdt_ovf & s_r.wdt_seen)
                          | (en_v[`F_RST] & det_rst_ovf);
        // overflow memory: an overflow in the clear cycle is kept
        if (clr) begin
            s_nxt.wdt_seen = 1'b0;
        end
        if (en_v[`F_WDT] && det_wdt_ovf) begin
            s_nxt.wdt_seen = 1'b1;
        end
        // set wins over clear
        s_nxt.fault = (clr ? 8'h00 : s_r.fault) | set_v;

        // status pin routing
        s_nxt.stat_a = route_out(s_r.route_a, active_flag_n,
                                 cmd_accept_flag,
                                 |s_r.fault);
        s_nxt.stat_b = route_out(s_r.route_b, active_flag_n,
                                 cmd_accept_flag,
                                 |s_r.fault);

        // apb register access
        unique case (paddr)
            `OFF_CHAN_STATE: rd_v[7:0] = {active_flag_n, cmd_accept_flag};
            `OFF_ROM_INFO:   rd_v[7:0] = s_r.rom_info;
            `OFF_FAULT:      rd_v[7:0] = s_r.fault;
            `OFF_SAFE_EN:    rd_v[7:0] = s_r.safe_en;
            `OFF_ROUTE:      rd_v[11:0] = {s_r.route_b, s_r.route_a};
            `OFF_CTRL:       rd_v = 32'h0000_0000;
            `OFF_PENDING:    rd_v[3:0] = s_r.pend;
            default:         mapped = 1'b0;
        endcase
        if (psel && !penable && !pwrite) begin
            s_nxt.prdata = rd_v;
        end
        if (psel && penable && pwrite) begin
            if (paddr == `OFF_ROM_INFO) begin
                s_nxt.rom_info = pwdata[7:0];
            end
            if (paddr == `OFF_SAFE_EN) begin
                s_nxt.safe_en = pwdata[7:0];
                if (pwdata[`F_WDT] && pwdata[`F_RST]) begin
                    s_nxt.safe_en[`F_WDT] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~mapped;
    assign prdata          = s_r.prdata;
    assign host_so         = s_r.so;
    assign status_out_a    = s_r.stat_a;
    assign status_out_b    = s_r.stat_b;
    assign phrase_num_bits = s_r.phrase;
    assign play_start      = s_r.start;

endmodule

/* File: core/status_fault_regs.svh */
// Purpose: constants of the status, fault and phrase command slice
// Assumes: apb byte offsets, host opcodes and field positions
// Notes:   definitions only
`ifndef STATUS_FAULT_REGS_SVH
`define STATUS_FAULT_REGS_SVH

// host opcodes
`define OP_READ_STATE   8'hb0
`define OP_ROM_INFO     8'hb4
`define OP_READ_FAULT   7'h5c
`define OP_STATUS_SEL   8'hc0
`define OP_WIDE_PHRASE  8'hc4
`define OP_FAULT_CLEAR  8'hff

// status select byte
`define SEL_ZERO_BIT    7
`define SEL_PORT_BIT    6
`define SEL_SRC_HI      5
`define SEL_SRC_LO      4
`define SRC_ACTIVE      2'h0
`define SRC_ACCEPT      2'h1
`define ROUTE_A_INIT    6'h11
`define ROUTE_B_INIT    6'h01

// wide phrase bytes
`define PH_ZERO_HI      7
`define PH_ZERO_LO      6
`define PH_CH_HI        5
`define PH_CH_LO        4

// fault byte positions
`define F_OSC           7
`define F_RST           6
`define F_WDT           5
`define F_FLASH         4
`define F_SHORT         3
`define F_TEMP          2
`define F_OPEN          1
`define F_CMD           0

// apb map
`define OFF_CHAN_STATE  8'h00
`define OFF_ROM_INFO    8'h04
`define OFF_FAULT       8'h08
`define OFF_SAFE_EN     8'h0c
`define OFF_ROUTE       8'h10
`define OFF_CTRL        8'h14
`define OFF_PENDING     8'h18
`define CTRL_START_BIT  0
`define CTRL_CLEAR_BIT  1
`define ROM_INFO_RESET  8'h00

`endif

/* File: test/cmd_slice_sva.sv */
// Purpose: port assertions for the status, fault and phrase slice
// Assumes: apb map and field positions of status_fault_regs.svh
// Notes:   bound to the top module; helper state mirrors apb writes and host_csn activity
`timescale 1ns/1ps
`include "status_fault_regs.svh"
module cmd_slice_sva #(
    parameter logic [7:0] ROM_INFO_INIT = 8'h00
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             host_csn,
    input wire logic [3:0]       active_flag_n,
    input wire logic [3:0]       cmd_accept_flag,
    input wire logic             det_overtemp,
    input wire logic             det_spk_open,
    input wire logic             status_out_a,
    input wire logic             status_out_b,
    input wire logic [3:0]       play_start
);
    logic       armed_r;
    logic       link_r;
    logic       start_r;
    logic [7:0] en_r;
    logic [7:0] rom_r;
    wire logic  wr_acc = psel && penable && pwrite;
    wire logic  rd_acc = psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
            link_r  <= 1'b0;
            start_r <= 1'b0;
            en_r    <= 8'h00;
            rom_r   <= ROM_INFO_INIT;
        end else begin
            link_r  <= link_r || !host_csn;
            start_r <= wr_acc && paddr == `OFF_CTRL && pwdata[0];
            if (wr_acc && paddr == `OFF_SAFE_EN) begin
                armed_r <= 1'b1;
                en_r    <= pwdata[7:0];
            end
            if (wr_acc && paddr == `OFF_ROM_INFO)
                rom_r <= pwdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence fault_rd;
        rd_acc && paddr == `OFF_FAULT;
    endsequence

    chan_state_a: assert property (
        rd_acc && paddr == `OFF_CHAN_STATE |-> prdata ==
        {24'h0, $past(active_flag_n), $past(cmd_accept_flag)})
        else $error("channel state readback differs from flags");
    pin_a_init_a: assert property (
        !link_r && $past(presetn) |->
        status_out_a == $past(cmd_accept_flag[0]))
        else $error("first status pin not on channel 0 accept");
    pin_b_init_a: assert property (
        !link_r && $past(presetn) |->
        status_out_b == $past(active_flag_n[0]))
        else $error("second status pin not on channel 0 active");
    fault_off_a: assert property (
        fault_rd |-> armed_r || prdata == 32'h0)
        else $error("fault seen before any detector enabled");
    overtemp_set_a: assert property (
        fault_rd |-> !($past(en_r[2], 2) && $past(det_overtemp, 2))
        || prdata[`F_TEMP])
        else $error("overtemperature bit missing");
    open_set_a: assert property (
        fault_rd |-> !($past(en_r[1], 2) && $past(det_spk_open, 2))
        || prdata[`F_OPEN])
        else $error("speaker open bit missing");
    rom_info_a: assert property (
        rd_acc && paddr == `OFF_ROM_INFO |-> prdata[7:0] == rom_r)
        else $error("rom information readback differs");
    start_cause_a: assert property (
        play_start != 4'h0 |-> start_r ##1 play_start == 4'h0)
        else $error("playback start without a start write");
endmodule

bind status_fault_readout_phrase_select cmd_slice_sva #(
    .ROM_INFO_INIT(ROM_INFO_INIT)
) i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .host_csn(host_csn), .active_flag_n(active_flag_n),
    .cmd_accept_flag(cmd_accept_flag), .det_overtemp(det_overtemp),
    .det_spk_open(det_spk_open), .status_out_a(status_out_a),
    .status_out_b(status_out_b), .play_start(play_start)
);

/* File: test/host_link_model.sv */
// Purpose: host side of the serial command link
// Assumes: mode 0, msb first, link clock period 16 pclk
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
module host_link_model (
    input  wire logic pclk,
    output logic      host_sck,
    output logic      host_csn,
    output logic      host_si,
    input  wire logic host_so
);
    initial begin
        host_sck = 1'b0;
        host_csn = 1'b1;
        host_si  = 1'b0;
    end

    // sends n bytes of d, first byte on top; r keeps the last byte on so
    task automatic frame(input int n, input logic [23:0] d,
                         output logic [7:0] r);
        logic [23:0] sh;
        sh = d;
        host_csn <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 8 * n; i++) begin
            host_si <= sh[23];
            sh = sh << 1;
            repeat (8) @(posedge pclk);
            r = {r[6:0], host_so};
            host_sck <= 1'b1;
            repeat (8) @(posedge pclk);
            host_sck <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        host_csn <= 1'b1;
        host_si  <= ~host_si;
        repeat (8) @(posedge pclk);
    endtask
endmodule

/* File: test/status_fault_readout_phrase_select_test.sv */
// Purpose: self-checking bench for the status, fault and phrase slice
// Assumes: zero-wait apb slave, host model on the serial link
// Notes:   flags and detectors are driven straight from the bench
`timescale 1ns/1ps
`include "status_fault_regs.svh"
module status_fault_readout_phrase_select_test;
    localparam logic [7:0] ROM0 = 8'h3c;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0;
    logic [3:0]       act_n = 4'hf;
    logic [3:0]       acc = 4'h0;
    logic [7:0]       det = 8'h00;
    logic [3:0]       started = 4'h0;
    logic [31:0]      prdata;
    logic [31:0]      rd;
    logic [7:0]       sr;
    logic             pready;
    logic             pslverr;
    logic             err;
    logic             host_sck;
    logic             host_csn;
    logic             host_si;
    logic             host_so;
    logic             status_out_a;
    logic             status_out_b;
    logic [3:0][11:0] phrase_num_bits;
    logic [3:0]       play_start;
    int               num_errors = 0;
    int               comparisons = 0;
    // select byte, active flags, accept flags, route, pin a, pin b
    logic [29:0]      tab [5] = '{{8'h4f, 4'hd, 4'h1, 12'h3d1, 2'b10},
        {8'h16, 4'hf, 4'hb, 12'h3d6, 2'b01},
        {8'h20, 4'hf, 4'hf, 12'h3e0, 2'b11},
        {8'h70, 4'hf, 4'hf, 12'hc20, 2'b11},
        {8'h80, 4'hf, 4'hf, 12'hc20, 2'b11}};

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) started <= started | play_start;

    status_fault_readout_phrase_select #(.ROM_INFO_INIT(ROM0)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_sck(host_sck),
        .host_csn(host_csn), .host_si(host_si), .host_so(host_so),
        .active_flag_n(act_n), .cmd_accept_flag(acc),
        .det_osc_stop(det[`F_OSC]), .det_rst_ovf(det[`F_RST]),
        .det_wdt_ovf(det[`F_WDT]), .det_flash(det[`F_FLASH]),
        .det_spk_short(det[`F_SHORT]), .det_overtemp(det[`F_TEMP]),
        .det_spk_open(det[`F_OPEN]), .status_out_a(status_out_a),
        .status_out_b(status_out_b), .phrase_num_bits(phrase_num_bits),
        .play_start(play_start)
    );
    host_link_model i_host (
        .pclk(pclk), .host_sck(host_sck), .host_csn(host_csn),
        .host_si(host_si), .host_so(host_so)
    );

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, rd, e);
    endtask
    task automatic sread(input logic [7:0] op);
        i_host.frame(2, {op, 16'h0}, sr);
    endtask
    task automatic pulse(input int b);
        det[b] <= 1'b1;
        @(posedge pclk);
        det[b] <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // the tests take about 5000 cycles; allow several times that
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            acc <= 4'(i);
            act_n <= ~4'(i);
            repeat (3) @(posedge pclk);
            check("pin_a", status_out_a, acc[0]);
            check("pin_b", status_out_b, act_n[0]);
        end
        rdchk("route", `OFF_ROUTE, 32'h051);
        rdchk("rom", `OFF_ROM_INFO, {24'h0, ROM0});
        det <= 8'hfe;
        repeat (4) @(posedge pclk);
        rdchk("fault_off", `OFF_FAULT, 32'h0);
        det <= 8'h00;
        act_n <= 4'h5;
        acc <= 4'ha;
        sread(`OP_READ_STATE);
        check("state", sr, 8'h5a);
        rdchk("chan", `OFF_CHAN_STATE, 32'h5a);
        check("chan_err", err, 1'b0);
        rdchk("unmapped", 8'h1c, 32'h0);
        check("unmapped_err", err, 1'b1);
        apb(1'b1, `OFF_ROM_INFO, 32'h96);
        sread(`OP_ROM_INFO);
        check("rom_byte", sr, 8'h96);
        $display("test reads finished");
        apb(1'b1, `OFF_SAFE_EN, 32'hbf);
        pulse(`F_WDT);
        rdchk("wdt", `OFF_FAULT, 32'h20);
        pulse(`F_WDT);
        rdchk("wdt2", `OFF_FAULT, 32'h60);
        i_host.frame(1, 24'h120000, sr);
        det <= 8'h9e;
        repeat (3) @(posedge pclk);
        rdchk("all", `OFF_FAULT, 32'hff);
        for (int p = 0; p < 2; p++) begin
            sread({`OP_READ_FAULT, 1'(p)});
            check("fault_byte", sr, 8'hff);
        end
        det <= 8'h04;
        apb(1'b1, `OFF_CTRL, 32'h2);
        rdchk("clear", `OFF_FAULT, 32'h04);
        det <= 8'h00;
        i_host.frame(1, 24'hff0000, sr);
        rdchk("clear2", `OFF_FAULT, 32'h0);
        apb(1'b1, `OFF_SAFE_EN, 32'h60);
        rdchk("safe_en", `OFF_SAFE_EN, 32'h40);
        pulse(`F_RST);
        rdchk("rst", `OFF_FAULT, 32'h40);
        $display("test faults finished");
        foreach (tab[i]) begin
            act_n <= tab[i][21:18];
            acc <= tab[i][17:14];
            i_host.frame(2, {8'hc0, tab[i][29:22], 8'h0}, sr);
            rdchk("route", `OFF_ROUTE, {20'h0, tab[i][13:2]});
            check("pin_a", status_out_a, tab[i][1]);
            check("pin_b", status_out_b, tab[i][0]);
        end
        sread({`OP_READ_FAULT, 1'b0});
        if (status_out_a === 1'b1 && sr === 8'h00) sread(8'hb8);
        check("fault_pin", sr, 8'h40);
        $display("test status finished");
        apb(1'b1, `OFF_SAFE_EN, 32'h01);
        acc <= 4'hb;
        i_host.frame(3, 24'hc41a34, sr);
        i_host.frame(3, 24'hc43fff, sr);
        i_host.frame(3, 24'hc42555, sr);
        check("ph1", phrase_num_bits[1], 12'ha34);
        check("ph3", phrase_num_bits[3], 12'hfff);
        check("ph2", phrase_num_bits[2], 12'h000);
        check("early", started, 4'h0);
        rdchk("pend", `OFF_PENDING, 32'ha);
        rdchk("cmd_fault", `OFF_FAULT, 32'h41);
        i_host.frame(3, 24'hc45bcd, sr);
        check("ph1_kept", phrase_num_bits[1], 12'ha34);
        apb(1'b1, `OFF_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        check("start", started, 4'ha);
        rdchk("pend0", `OFF_PENDING, 32'h0);
        $display("test phrase finished");
        wrap_up();
    end
endmodule
